// ---- design/etdff_pkg.sv ----
package etdff_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CNT_W         = 16;

  localparam int unsigned LATENCY_DEF_NS = 40;
  localparam int unsigned MINW_DEF_NS    = 20;
  localparam int unsigned SRDLY_DEF_NS   = 40;

  localparam logic [CNT_W-1:0] LATENCY_DEF =
    CNT_W'((LATENCY_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MINW_DEF    =
    CNT_W'((MINW_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SRDLY_DEF   =
    CNT_W'((SRDLY_DEF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE     = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX     = 16'hffff;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_LATENCY = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MINW    = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_SRDLY   = 4'hc;

  localparam int unsigned CTRL_EDGE_BIT  = 0;
  localparam int unsigned CTRL_PWRON_BIT = 1;
  localparam int unsigned CTRL_SREN_BIT  = 2;
  localparam int unsigned STAT_Q_BIT     = 8;
  localparam int unsigned STAT_BUSY_BIT  = 9;
  localparam int unsigned STAT_SR_BIT    = 10;

  localparam logic EDGE_0_TO_1 = 1'b0;
  localparam logic EDGE_1_TO_0 = 1'b1;
  localparam logic EDGE_RST    = EDGE_0_TO_1;
  localparam logic PWRON_RST   = 1'b0;
  localparam logic SREN_RST    = 1'b0;

  typedef enum logic [1:0] {
    ETDFF_IDLE  = 2'b00,
    ETDFF_WIDTH = 2'b01,
    ETDFF_HOLD  = 2'b11
  } etdff_state_t;

endpackage : etdff_pkg

// ---- design/etdff_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module etdff_top (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  input  wire logic [etdff_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [etdff_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [etdff_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic                           ff_clk_in,
  input  wire logic                           ff_data_in,
  input  wire logic                           ff_set_in,
  input  wire logic                           ff_reset_in,
  output logic                                ff_q_out
);
  import etdff_pkg::*;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic active_level(input logic sel, input logic lvl);
    active_level = (sel == EDGE_1_TO_0) ? ~lvl : lvl;
  endfunction : active_level

  function automatic logic [CNT_W-1:0] nonzero(input logic [DATA_W-1:0] v);
    nonzero = (v[CNT_W-1:0] == '0) ? CNT_ONE : v[CNT_W-1:0];
  endfunction : nonzero

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic             edge_sel_q,  edge_sel_d;
  logic             pwron_q,     pwron_d;
  logic             sren_q,      sren_d;
  logic [CNT_W-1:0] edge_to_q_latency_q, edge_to_q_latency_d;
  logic [CNT_W-1:0] minw_q,      minw_d;
  logic [CNT_W-1:0] srdly_q,     srdly_d;
  logic [DATA_W-1:0] rdata_q,    rdata_d;

  // Core state, declared here for status readback
  etdff_state_t     state_q,     state_d;
  logic             q_q,         q_d;
  logic             sr_act_q,    sr_act_d;

  always_comb begin
    edge_sel_d          = edge_sel_q;
    pwron_d             = pwron_q;
    sren_d              = sren_q;
    edge_to_q_latency_d = edge_to_q_latency_q;
    minw_d              = minw_q;
    srdly_d             = srdly_q;
    rdata_d             = '0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          edge_sel_d = reg_wdata[CTRL_EDGE_BIT];
          pwron_d    = reg_wdata[CTRL_PWRON_BIT];
          sren_d     = reg_wdata[CTRL_SREN_BIT];
        end
        ADDR_LATENCY: edge_to_q_latency_d = nonzero(reg_wdata);
        ADDR_MINW:    minw_d              = nonzero(reg_wdata);
        ADDR_SRDLY:   srdly_d             = nonzero(reg_wdata);
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          rdata_d[CTRL_EDGE_BIT]  = edge_sel_q;
          rdata_d[CTRL_PWRON_BIT] = pwron_q;
          rdata_d[CTRL_SREN_BIT]  = sren_q;
          rdata_d[STAT_Q_BIT]     = q_q;
          rdata_d[STAT_BUSY_BIT]  = (state_q != ETDFF_IDLE);
          rdata_d[STAT_SR_BIT]    = sr_act_q;
        end
        ADDR_LATENCY: rdata_d[CNT_W-1:0] = edge_to_q_latency_q;
        ADDR_MINW:    rdata_d[CNT_W-1:0] = minw_q;
        ADDR_SRDLY:   rdata_d[CNT_W-1:0] = srdly_q;
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel_q          <= EDGE_RST;
      pwron_q             <= PWRON_RST;
      sren_q              <= SREN_RST;
      edge_to_q_latency_q <= LATENCY_DEF;
      minw_q              <= MINW_DEF;
      srdly_q             <= SRDLY_DEF;
      rdata_q             <= '0;
    end else begin
      edge_sel_q          <= edge_sel_d;
      pwron_q             <= pwron_d;
      sren_q              <= sren_d;
      edge_to_q_latency_q <= edge_to_q_latency_d;
      minw_q              <= minw_d;
      srdly_q             <= srdly_d;
      rdata_q             <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // Flip-flop core
  // ==========================================================
  logic             clk_prev_q,  clk_prev_d;
  logic             started_q,   started_d;
  logic             cap_q,       cap_d;
  logic [CNT_W-1:0] elapsed_q,   elapsed_d;
  logic             sr_val_q,    sr_val_d;
  logic [CNT_W-1:0] sr_cnt_q,    sr_cnt_d;
  logic             trig_edge;
  logic             trig_lvl;
  logic             sr_req;
  logic             sr_tgt;

  assign trig_lvl  = active_level(edge_sel_q, ff_clk_in);
  assign trig_edge = trig_lvl & ~active_level(edge_sel_q, clk_prev_q);
  assign sr_req    = sren_q & (ff_set_in | ff_reset_in);
  assign sr_tgt    = ~ff_reset_in;  // Reset wins over set

  always_comb begin
    clk_prev_d = ff_clk_in;
    state_d    = state_q;
    q_d        = q_q;
    started_d  = started_q;
    cap_d      = cap_q;
    elapsed_d  = (elapsed_q == CNT_MAX) ? elapsed_q : elapsed_q + CNT_ONE;
    sr_act_d   = sr_act_q;
    sr_val_d   = sr_val_q;
    sr_cnt_d   = sr_cnt_q;

    if (!started_q) begin
      q_d = pwron_q;
    end

    // Set/reset path, own delay, glitches absorbed
    if (!sr_req) begin
      sr_act_d = 1'b0;
      sr_cnt_d = '0;
    end else if (!sr_act_q || sr_val_q != sr_tgt) begin
      sr_act_d = 1'b1;
      sr_val_d = sr_tgt;
      sr_cnt_d = CNT_ONE;
    end else begin
      sr_cnt_d = (sr_cnt_q == CNT_MAX) ? sr_cnt_q : sr_cnt_q + CNT_ONE;
      if (sr_cnt_q >= srdly_q) begin
        q_d       = sr_val_q;
        started_d = 1'b1;
      end
    end

    if (sr_req) begin
      state_d = ETDFF_IDLE;
    end else if (trig_edge) begin
      // A newer edge cancels any pending update
      state_d   = ETDFF_WIDTH;
      cap_d     = ff_data_in;
      elapsed_d = CNT_ONE;
    end else begin
      case (state_q)
        ETDFF_IDLE: state_d = ETDFF_IDLE;
        ETDFF_WIDTH: begin
          if (!trig_lvl) begin
            state_d = ETDFF_IDLE;
          end else if (elapsed_q >= minw_q) begin
            if (elapsed_q >= edge_to_q_latency_q) begin
              q_d       = cap_q;
              started_d = 1'b1;
              state_d   = ETDFF_IDLE;
            end else begin
              state_d = ETDFF_HOLD;
            end
          end
        end
        ETDFF_HOLD: begin
          if (elapsed_q >= edge_to_q_latency_q) begin
            q_d       = cap_q;
            started_d = 1'b1;
            state_d   = ETDFF_IDLE;
          end
        end
        default: state_d = ETDFF_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_q <= 1'b0;
      state_q    <= ETDFF_IDLE;
      q_q        <= PWRON_RST;
      started_q  <= 1'b0;
      cap_q      <= 1'b0;
      elapsed_q  <= '0;
      sr_act_q   <= 1'b0;
      sr_val_q   <= 1'b0;
      sr_cnt_q   <= '0;
    end else begin
      clk_prev_q <= clk_prev_d;
      state_q    <= state_d;
      q_q        <= q_d;
      started_q  <= started_d;
      cap_q      <= cap_d;
      elapsed_q  <= elapsed_d;
      sr_act_q   <= sr_act_d;
      sr_val_q   <= sr_val_d;
      sr_cnt_q   <= sr_cnt_d;
    end
  end

  assign ff_q_out = q_q;

endmodule : etdff_top

`default_nettype wire

// ---- dv/etdff_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module etdff_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        ff_clk_in,
  input wire logic        ff_data_in,
  input wire logic        ff_set_in,
  input wire logic        ff_reset_in,
  input wire logic        ff_q_out
);
  // ======
  // Shadow of edge select and set/reset enable
  logic [1:0] ctl_q, ctl_d;
  logic       act, en, sr;
  always_comb begin
    ctl_d = ctl_q;
    if (reg_wr && reg_addr == 4'h0) ctl_d = {reg_wdata[2], reg_wdata[0]};
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ctl_q <= 2'h0;
    else ctl_q <= ctl_d;
  end
  assign act = ff_clk_in ^ ctl_q[0];
  assign en  = !ctl_q[1];
  assign sr  = ctl_q[1];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_capture_data: assert property (en && $rose(act) ##1 en && act |=> ##1
    ff_q_out == $past(ff_data_in, 3)) else $error("capture wrong");
  chk_no_early: assert property (en && $rose(act) ##1 act |->
    $stable(ff_q_out) [*2]) else $error("output too early");
  chk_narrow_clk: assert property (en && $rose(act) ##1 !act |=>
    $stable(ff_q_out) [*2]) else $error("narrow pulse taken");
  chk_reset_force: assert property ((sr && ff_reset_in) [*3] |=> !ff_q_out)
    else $error("reset not forced");
  chk_set_force: assert property ((sr && ff_set_in && !ff_reset_in) [*3] |=> ff_q_out)
    else $error("set not forced");
  chk_sr_absorb: assert property (sr && $rose(ff_reset_in) ##1 !ff_reset_in |=>
    $stable(ff_q_out) [*2]) else $error("short reset taken");
  chk_delay_nonzero: assert property (reg_rd && reg_addr != 4'h0 && reg_addr[1:0] == 2'h0 |=>
    reg_rdata[15:0] != 16'h0000 && reg_rdata[31:16] == 16'h0000) else $error("delay zero");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not idle");
  cover property (en && $rose(act) ##1 act);
  cover property (ctl_q[0] && $fell(ff_clk_in));
  cover property ((sr && ff_set_in) [*3]);
endmodule : etdff_props
bind etdff_top etdff_props u_props (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .ff_clk_in, .ff_data_in, .ff_set_in, .ff_reset_in, .ff_q_out);
`default_nettype wire

// ---- dv/etdff_far.sv ----
`timescale 1ns/10ps
`default_nettype none
module etdff_far (
  input  wire logic ref_clk,
  output logic      clk_o,
  output logic      d_o,
  output logic      set_o,
  output logic      rst_o
);
  // ======
  // Surrounding logic; data turns over once the edge has passed
  initial begin
    {clk_o, d_o, set_o, rst_o} = 4'h0;
  end
  task automatic pulse(input logic lvl, input int w, input logic d);
    @(posedge ref_clk);
    clk_o <= lvl;
    d_o   <= d;
    @(posedge ref_clk);
    d_o <= ~d;
    repeat (w - 1) @(posedge ref_clk);
    clk_o <= ~lvl;
    repeat (4) @(posedge ref_clk);
  endtask : pulse
  task automatic level(input logic v);
    @(posedge ref_clk);
    clk_o <= v;
    repeat (4) @(posedge ref_clk);
  endtask : level
  task automatic sr(input logic rs, input int n);
    @(posedge ref_clk);
    set_o <= !rs;
    rst_o <= rs;
    repeat (n) @(posedge ref_clk);
    {set_o, rst_o} <= 2'h0;
    repeat (4) @(posedge ref_clk);
  endtask : sr
endmodule : etdff_far
`default_nettype wire

// ---- dv/tb_etdff_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_etdff_top;
  import etdff_pkg::*;
  logic        ref_clk   = 1'h0;
  logic        rst_n     = 1'h0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr    = 1'h0;
  logic        reg_rd    = 1'h0;
  logic [31:0] reg_rdata;
  logic        fclk, fd, fset, frst, q;
  int          n_mismatch = 0;
  int          n_compared = 0;
  always #10 ref_clk = ~ref_clk;
  etdff_far far (.ref_clk, .clk_o(fclk), .d_o(fd), .set_o(fset), .rst_o(frst));
  etdff_top dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ff_clk_in(fclk), .ff_data_in(fd), .ff_set_in(fset), .ff_reset_in(frst), .ff_q_out(q));
  // ======
  // Bus and compare helpers
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, v};
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    cmp("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic t_regs;
    logic [3:0]  a [3] = '{ADDR_LATENCY, ADDR_MINW, ADDR_SRDLY};
    logic [15:0] v [3] = '{LATENCY_DEF, MINW_DEF, SRDLY_DEF};
    wr(ADDR_CTRL, 32'h0000_0002);
    rd(ADDR_CTRL, 32'h0000_0102);
    wr(ADDR_CTRL, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      rd(a[i], 32'(v[i]));
      wr(a[i], 32'h0000_0000);
      rd(a[i], 32'h0000_0001);
      wr(a[i], {16'hffff, v[i]});
      rd(a[i], 32'(v[i]));
    end
    rd(4'h2, 32'h0000_0000);
    wr(4'h6, 32'h0000_0005);
    rd(4'h6, 32'h0000_0000);
  endtask : t_regs
  task automatic t_capture;
    for (int i = 0; i < 4; i++) begin
      far.pulse(1'h1, 2 + i, i[0]);
      cmp("ff_q_out", 32'(i[0]), 32'(q));
    end
    far.pulse(1'h1, 1, 1'h0);
    cmp("ff_q_out", 32'h0000_0001, 32'(q));
  endtask : t_capture
  task automatic t_setreset;
    wr(ADDR_CTRL, 32'h0000_0004);
    far.sr(1'h1, 4);
    cmp("ff_q_out", 32'h0000_0000, 32'(q));
    far.sr(1'h0, 4);
    cmp("ff_q_out", 32'h0000_0001, 32'(q));
    far.sr(1'h1, 1);
    cmp("ff_q_out", 32'h0000_0001, 32'(q));
    fork
      far.sr(1'h1, 4);
      begin
        repeat (2) @(posedge ref_clk);
        rd(ADDR_CTRL, 32'h0000_0504);
      end
    join
    fork
      far.sr(1'h0, 8);
      far.pulse(1'h1, 2, 1'h0);
    join
    cmp("ff_q_out", 32'h0000_0001, 32'(q));
  endtask : t_setreset
  task automatic t_falling;
    wr(ADDR_CTRL, 32'h0000_0000);
    far.level(1'h1);
    wr(ADDR_CTRL, 32'h0000_0001);
    far.pulse(1'h0, 2, 1'h1);
    cmp("ff_q_out", 32'h0000_0001, 32'(q));
    far.pulse(1'h0, 1, 1'h0);
    cmp("ff_q_out", 32'h0000_0001, 32'(q));
    fork
      far.pulse(1'h0, 2, 1'h0);
      begin
        repeat (2) @(posedge ref_clk);
        rd(ADDR_CTRL, 32'h0000_0301);
      end
    join
    cmp("ff_q_out", 32'h0000_0000, 32'(q));
  endtask : t_falling
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (16) @(posedge ref_clk);
    cmp("ff_q_out", 32'h0000_0000, 32'(q));
    rst_n <= 1'h1;
    t_regs();
    t_capture();
    t_setreset();
    t_falling();
    tally_and_finish();
  end
  // Span far above the 175 or so cycles the tests need
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : tb_etdff_top
`default_nettype wire
